// >>> rtl/nv_timekeeping_ram_core.sv
// nonvolatile timekeeping memory core: sram, clock, alarm, watchdog, power reset
`timescale 1ns/10ps
`include "nvtk_params.svh"
module nv_timekeeping_ram_core #(
    parameter int unsigned TICK_CYCLES = `CLK_HZ / `TICK_HZ,
    parameter int unsigned POR_CYCLES  = (`POR_HOLD_MS * `CLK_HZ + 999) / 1000,
    parameter int unsigned WDOG_UNIT   = (`WDOG_UNIT_MS * `CLK_HZ) / 1000,
    parameter int unsigned MEM_DEPTH   = `MEM_BYTES
) (
    // clock and reset
    input  wire logic                  CLOCK_I,
    input  wire logic                  RESET_I,
    // host byte-wide port
    input  wire nvtk_pkg::host_bus_type BUS_I,
    output logic [7:0]                 DATA_O,
    output logic                       DATA_OE_O,
    // supply monitor, high while supply in tolerance
    input  wire logic                  POWER_OK_I,
    // open-drain interrupt pin, active low
    input  wire logic                  IRQ_N_I,
    output logic                       IRQ_N_O,
    output logic                       IRQ_N_OE_O,
    // open-drain reset pin, active low
    input  wire logic                  RST_N_I,
    output logic                       RST_N_O,
    output logic                       RST_N_OE_O
);
    import nvtk_pkg::*;

    // the reset hold check spans eight cycles, so shorter holds are refused
    if (MEM_DEPTH != (1 << `ADDR_W) || TICK_CYCLES < 2
        || POR_CYCLES < 8 || WDOG_UNIT < 1) begin : g_check
        $error("nv_timekeeping_ram_core: unsupported parameter values");
    end

    // top sixteen addresses belong to the clock
    function automatic logic is_clk(input logic [14:0] a);
        return a[14:4] == `CLK_TOP;
    endfunction

    // one BCD step, no wrap
    function automatic logic [7:0] bcd_next(input logic [7:0] v);
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // last date of a month; year divisible by four is leap, right through 2099
    function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02:                      return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default:                    return 8'h31;
        endcase
    endfunction

    // one second forward through the whole calendar
    function automatic time_type advance(input time_type t);
        time_type n;
        n = t;
        n.sec = (t.sec == `MAX_SEC) ? 8'h00 : bcd_next(t.sec);
        if (t.sec == `MAX_SEC) begin
            n.min = (t.min == `MAX_SEC) ? 8'h00 : bcd_next(t.min);
            if (t.min == `MAX_SEC) begin
                n.hour = (t.hour == `MAX_HOUR) ? 8'h00 : bcd_next(t.hour);
                if (t.hour == `MAX_HOUR) begin
                    n.day = (t.day == `MAX_DAY) ? `MIN_ONE : bcd_next(t.day);
                    n.date = (t.date == last_date(t.month, t.year)) ? `MIN_ONE
                                                                    : bcd_next(t.date);
                    if (t.date == last_date(t.month, t.year)) begin
                        n.month = (t.month == `MAX_MONTH) ? `MIN_ONE : bcd_next(t.month);
                        if (t.month == `MAX_MONTH) begin
                            n.year = (t.year == `MAX_YEAR) ? 8'h00 : bcd_next(t.year);
                            if (t.year == `MAX_YEAR)
                                n.cent = (t.cent == `MAX_CENT) ? 8'h00 : bcd_next(t.cent);
                        end
                    end
                end
            end
        end
        return n;
    endfunction

    // counting set shown as one external byte; control bits kept from old
    function automatic logic [7:0] to_ext(input time_type t, input logic [3:0] i,
                                          input logic [7:0] old);
        case (i)
            `IDX_CTRL:  return {old[7:6], t.cent[5:0]};
            `IDX_SEC:   return {old[7], t.sec[6:0]};
            `IDX_MIN:   return t.min;
            `IDX_HOUR:  return t.hour;
            `IDX_DAY:   return {old[7:3], t.day[2:0]};
            `IDX_DATE:  return t.date;
            `IDX_MONTH: return t.month;
            `IDX_YEAR:  return t.year;
            default:    return old;
        endcase
    endfunction

    host_bus_type bus_s1_r;          // first synchroniser stage
    host_bus_type bus_s2_r;          // settled pins
    host_bus_type bus_s3_r;          // previous settled pins, for edges
    logic         pwr_s1_r;          // supply sync stage one
    logic         pwr_s2_r;          // supply sync stage two
    logic [7:0]   mem [MEM_DEPTH];   // storage array, never reset
    logic [7:0]   ext_r [16];        // external set and control bytes
    time_type     int_r;             // internal counting set
    logic [31:0]  tick_cnt_r;        // one second prescaler
    logic         tick_r;            // one second pulse
    logic         tick_d_r;          // pulse after the count took it
    logic         af_r;              // alarm flag
    logic         wdf_r;             // watchdog flag
    logic [31:0]  wd_pre_r;          // watchdog unit prescaler
    logic [6:0]   wd_cnt_r;          // watchdog units elapsed
    logic [31:0]  por_cnt_r;         // reset hold countdown

    // pins cross into the clock domain through two flops
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            bus_s1_r <= '1;
            bus_s2_r <= '1;
            bus_s3_r <= '1;
            pwr_s1_r <= 1'b0;
            pwr_s2_r <= 1'b0;
        end else begin
            bus_s1_r <= BUS_I;
            bus_s2_r <= bus_s1_r;
            bus_s3_r <= bus_s2_r;
            pwr_s1_r <= POWER_OK_I;
            pwr_s2_r <= pwr_s1_r;
        end
    end

    // bus decode; out of tolerance supply shuts the port off
    logic       sel;
    logic       rd_act;
    logic       rd_end;
    logic       wr_end;
    logic       hold;
    logic       w_fall;
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;
    logic       wd_fire;
    logic       alarm_hit;
    assign sel      = pwr_s2_r && !bus_s2_r.ce_n;                                 // R13 R17
    assign rd_act   = sel && bus_s2_r.we_n;                                       // R14
    // a read ends when the settled pins leave it; flags clear only then
    assign rd_end   = pwr_s2_r && !bus_s3_r.ce_n && bus_s3_r.we_n && !rd_act;
    // commit at the end of the write, when data is known to have settled
    assign wr_end   = pwr_s2_r && !bus_s3_r.ce_n && !bus_s3_r.we_n
                      && (bus_s2_r.ce_n || bus_s2_r.we_n);                        // R15
    assign wr_idx   = bus_s3_r.address_lines[3:0];
    assign rd_idx   = bus_s2_r.address_lines[3:0];
    assign hold     = ext_r[`IDX_CTRL][`BIT_W] || ext_r[`IDX_CTRL][`BIT_R];       // R7
    assign w_fall   = wr_end && is_clk(bus_s3_r.address_lines) && wr_idx == `IDX_CTRL
                      && ext_r[`IDX_CTRL][`BIT_W] && !bus_s3_r.data_lines[`BIT_W];

    // plain storage below the clock bytes
    always_ff @(posedge CLOCK_I) begin
        if (wr_end && !is_clk(bus_s3_r.address_lines))                           // R1 R2
            mem[bus_s3_r.address_lines] <= bus_s3_r.data_lines;
    end

    // read data and drive; lines float unless selected with output enable
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            DATA_O    <= 8'h00;
            DATA_OE_O <= 1'b0;
        end else begin
            DATA_OE_O <= rd_act && !bus_s2_r.oe_n;                                // R14 R18
            if (!is_clk(bus_s2_r.address_lines))
                DATA_O <= mem[bus_s2_r.address_lines];
            else if (rd_idx == `IDX_FLAGS)                                        // R3
                DATA_O <= {wdf_r, af_r, 6'h00};
            else
                DATA_O <= ext_r[rd_idx];
        end
    end

    // one second timebase
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r     <= 1'b0;
            tick_d_r   <= 1'b0;
        end else begin
            tick_r     <= tick_cnt_r == TICK_CYCLES - 1;
            tick_d_r   <= tick_r;
            tick_cnt_r <= (tick_cnt_r == TICK_CYCLES - 1) ? 32'h0000_0000 : tick_cnt_r + 32'h1;
        end
    end

    // internal set counts regardless of the freeze bits; clearing W loads it
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            int_r <= '{cent: 8'h00, year: 8'h00, month: `MIN_ONE, date: `MIN_ONE,
                       day: `MIN_ONE, hour: 8'h00, min: 8'h00, sec: 8'h00};
        end else if (w_fall) begin
            int_r <= '{cent: {2'h0, ext_r[`IDX_CTRL][5:0]}, year: ext_r[`IDX_YEAR],
                       month: ext_r[`IDX_MONTH], date: ext_r[`IDX_DATE],
                       day: {5'h00, ext_r[`IDX_DAY][2:0]}, hour: ext_r[`IDX_HOUR],
                       min: ext_r[`IDX_MIN], sec: {1'b0, ext_r[`IDX_SEC][6:0]}};
        end else if (tick_r && !ext_r[`IDX_SEC][`BIT_OSC_N]) begin
            int_r <= advance(int_r);                                              // R4 R5 R8
        end
    end

    // external set: host writes, else follows the counting set unless frozen
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            for (int i = 0; i < 16; i++)
                ext_r[i] <= 8'h00;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (wr_end && is_clk(bus_s3_r.address_lines) && wr_idx == 4'(i))  // R3 R6
                    ext_r[i] <= bus_s3_r.data_lines;
                else if (!hold)                                                   // R6 R7
                    ext_r[i] <= to_ext(int_r, 4'(i), ext_r[i]);
            end
        end
    end

    // alarm compares after each count step; bit 7 of an alarm byte masks it
    assign alarm_hit = tick_d_r
        && (ext_r[`IDX_AL_SEC][`BIT_AL_MASK]  || ext_r[`IDX_AL_SEC][6:0]  == int_r.sec[6:0])
        && (ext_r[`IDX_AL_MIN][`BIT_AL_MASK]  || ext_r[`IDX_AL_MIN][6:0]  == int_r.min[6:0])
        && (ext_r[`IDX_AL_HOUR][`BIT_AL_MASK] || ext_r[`IDX_AL_HOUR][6:0] == int_r.hour[6:0])
        && (ext_r[`IDX_AL_DATE][`BIT_AL_MASK] || ext_r[`IDX_AL_DATE][6:0] == int_r.date[6:0]);

    // watchdog restarts on any write of its byte; zero timeout disables it
    assign wd_fire = ext_r[`IDX_WDOG][6:0] != 7'h00 && wd_cnt_r == ext_r[`IDX_WDOG][6:0];
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || (wr_end && is_clk(bus_s3_r.address_lines) && wr_idx == `IDX_WDOG)
            || wd_fire) begin
            wd_pre_r <= 32'h0000_0000;
            wd_cnt_r <= 7'h00;
        end else if (wd_pre_r == WDOG_UNIT - 1) begin
            wd_pre_r <= 32'h0000_0000;
            wd_cnt_r <= wd_cnt_r + 7'h01;                                         // R11
        end else begin
            wd_pre_r <= wd_pre_r + 32'h1;
        end
    end

    // sticky flags; the end of a flag byte read clears, so the host sees them first
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            af_r  <= 1'b0;
            wdf_r <= 1'b0;
        end else begin
            logic clr;
            clr   = rd_end && is_clk(bus_s3_r.address_lines) && wr_idx == `IDX_FLAGS;
            af_r  <= alarm_hit || (af_r && !clr);                                 // R9
            wdf_r <= wd_fire || (wdf_r && !clr);                                  // R11
        end
    end

    // reset hold: loaded while supply is bad or on a steered watchdog timeout
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || !pwr_s2_r || (wd_fire && ext_r[`IDX_WDOG][`BIT_WDS]))      // R11 R12
            por_cnt_r <= POR_CYCLES;
        else if (por_cnt_r != 32'h0000_0000)
            por_cnt_r <= por_cnt_r - 32'h1;                                       // R16
    end

    // open-drain pins only ever pull low
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            IRQ_N_O    <= 1'b0;
            IRQ_N_OE_O <= 1'b0;
            RST_N_O    <= 1'b0;
            RST_N_OE_O <= 1'b1;
        end else begin
            IRQ_N_O    <= 1'b0;
            RST_N_O    <= 1'b0;
            IRQ_N_OE_O <= (af_r && ext_r[`IDX_INT_EN][`BIT_AE]
                           && (pwr_s2_r || ext_r[`IDX_INT_EN][`BIT_ABE]))         // R9 R10
                          || (wdf_r && !ext_r[`IDX_WDOG][`BIT_WDS]);              // R11
            RST_N_OE_O <= !pwr_s2_r || por_cnt_r != 32'h0000_0000;                // R12 R16
        end
    end

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);

    a_deselect_float: assert property (!pwr_s2_r |=> !DATA_OE_O)                 // R13
        else $error("data driven while supply bad");
    a_ce_idle_float: assert property (bus_s2_r.ce_n |=> !DATA_OE_O)              // R17
        else $error("data driven with chip enable idle");
    a_oe_off_float: assert property (bus_s2_r.oe_n |=> !DATA_OE_O)               // R18
        else $error("data driven with output enable idle");
    a_read_drive: assert property (sel && bus_s2_r.we_n && !bus_s2_r.oe_n |=> DATA_OE_O) // R14
        else $error("read not driven");
    a_mem_write: assert property (wr_end && !is_clk(bus_s3_r.address_lines)      // R15
        |=> mem[$past(bus_s3_r.address_lines)] == $past(bus_s3_r.data_lines))
        else $error("write not stored");
    a_power_reset: assert property (!pwr_s2_r |=> RST_N_OE_O)                    // R12
        else $error("reset not driven on supply loss");
    a_reset_hold: assert property ($rose(pwr_s2_r) |=> RST_N_OE_O [*8])          // R16
        else $error("reset released too early");
    a_count_runs: assert property (tick_r && !ext_r[`IDX_SEC][`BIT_OSC_N] && !w_fall // R8
        |=> int_r != $past(int_r))
        else $error("counting set did not advance");
    a_snapshot: assert property (hold && !wr_end |=> ext_r[`IDX_SEC] == $past(ext_r[`IDX_SEC])) // R7
        else $error("frozen set changed");
    a_hour_range: assert property (int_r.hour <= `MAX_HOUR)                      // R4
        else $error("hour out of 24-hour range");
    a_date_range: assert property (int_r.date <= last_date(int_r.month, int_r.year)) // R5
        else $error("date beyond month end");
    a_alarm_irq: assert property (alarm_hit                                     // R9
        ##1 (ext_r[`IDX_INT_EN][`BIT_AE] && pwr_s2_r) |=> IRQ_N_OE_O)
        else $error("alarm did not pull interrupt");
    a_wdog_reset: assert property (wd_fire && ext_r[`IDX_WDOG][`BIT_WDS] |=> ##1 RST_N_OE_O) // R11
        else $error("watchdog did not pull reset");
endmodule

// >>> common/nvtk_params.svh
// constants of the nonvolatile timekeeping memory core
// Overview of operation
// R1 - 32k byte-wide nonvolatile memory on parallel port
// R2 - clock registers replace top sixteen addresses
// R3 - clock registers use ordinary memory bus cycles
// R4 - packed BCD time, 24-hour hours, century
// R5 - automatic month length and leap year
// R6 - internal counting set plus external host set
// R7 - host can freeze updates of external set
// R8 - internal set counts whenever oscillator runs
// R9 - alarm match asserts open-drain interrupt
// R10 - alarm works on battery when enabled
// R11 - watchdog timeout drives interrupt or reset
// R12 - supply loss drives reset output
// R13 - out of tolerance supply deselects device
// R14 - chip enable, write high: read, drive on output enable
// R15 - write while chip and write enable active
// R16 - reset held 40 to 200 ms after power
// R17 - chip enable inactive: data lines float
// R18 - read with output enable off: lines float
`ifndef NVTK_PARAMS_SVH
`define NVTK_PARAMS_SVH
`define CLK_HZ          10000000
`define TICK_HZ         1
`define POR_HOLD_MS     40
`define WDOG_UNIT_MS    10
`define ADDR_W          15
`define MEM_BYTES       32768
`define CLK_TOP         11'h7FF
// clock register indices inside the top sixteen bytes
`define IDX_FLAGS       4'h0
`define IDX_AL_SEC      4'h2
`define IDX_AL_MIN      4'h3
`define IDX_AL_HOUR     4'h4
`define IDX_AL_DATE     4'h5
`define IDX_INT_EN      4'h6
`define IDX_WDOG        4'h7
`define IDX_CTRL        4'h8
`define IDX_SEC         4'h9
`define IDX_MIN         4'hA
`define IDX_HOUR        4'hB
`define IDX_DAY         4'hC
`define IDX_DATE        4'hD
`define IDX_MONTH       4'hE
`define IDX_YEAR        4'hF
// bit positions
`define BIT_W           7
`define BIT_R           6
`define BIT_OSC_N       7
`define BIT_AL_MASK     7
`define BIT_AE          7
`define BIT_ABE         6
`define BIT_WDS         7
`define BIT_WDF         7
`define BIT_AF          6
// calendar limits
`define MAX_SEC         8'h59
`define MAX_HOUR        8'h23
`define MAX_DAY         8'h07
`define MAX_MONTH       8'h12
`define MAX_YEAR        8'h99
`define MAX_CENT        8'h39
`define MIN_ONE         8'h01
`endif

// >>> common/nvtk_pkg.sv
// types of the nonvolatile timekeeping memory core
package nvtk_pkg;
    // host side pins of the byte-wide port, all sampled together
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [14:0] address_lines;
        logic [7:0]  data_lines;
    } host_bus_type;
    // internal counting set, packed BCD
    typedef struct packed {
        logic [7:0] cent;
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } time_type;
endpackage

// >>> bench/host_model.sv
// host processor model on the byte-wide port of the timekeeping core
`timescale 1ns/10ps
module host_model (
    // clock
    input  wire logic              clk_i,
    // byte-wide port towards the core
    output nvtk_pkg::host_bus_type bus_o,
    input  wire logic [7:0]        data_i,
    input  wire logic              data_oe_i,
    // open-drain pins, pulled up on the board
    input  wire logic              irq_n_i,
    input  wire logic              irq_n_oe_i,
    input  wire logic              rst_n_i,
    input  wire logic              rst_n_oe_i,
    output logic                   irq_pin_o,
    output logic                   rst_pin_o
);
    import nvtk_pkg::*;
    // pull-ups win whenever the core lets go of a pin
    assign irq_pin_o = irq_n_oe_i ? irq_n_i : 1'b1;
    assign rst_pin_o = rst_n_oe_i ? rst_n_i : 1'b1;
    // idle bus at time zero
    initial bus_o = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, address_lines: 15'h0000,
                      data_lines: 8'h00};
    // one bus phase: pins set after an edge, then held n edges
    task automatic cyc(input logic ce_n, input logic oe_n, input logic we_n,
                       input logic [14:0] addr, input logic [7:0] data, input int n);
        @(posedge clk_i);
        // released data lines toggle so a stale value never looks valid
        bus_o <= '{ce_n: ce_n, oe_n: oe_n, we_n: we_n, address_lines: addr,
                   data_lines: we_n ? ~bus_o.data_lines : data};
        repeat (n) begin
            @(posedge clk_i);
            if (we_n) begin
                bus_o.data_lines <= ~bus_o.data_lines;
            end
        end
    endtask
    // deselected, address kept so a write ends on a stable address
    task automatic idle(input int n);
        cyc(1'b1, 1'b1, 1'b1, bus_o.address_lines, 8'h00, n);
    endtask
    // write: both enables low, then back high for the recovery time
    task automatic wr(input logic [14:0] addr, input logic [7:0] data);
        cyc(1'b0, 1'b1, 1'b0, addr, data, 4);
        idle(4);
    endtask
    // read: data taken at the last held edge, past the three-edge latency
    task automatic rd(input logic [14:0] addr, output logic [7:0] data, output logic oe);
        cyc(1'b0, 1'b0, 1'b1, addr, 8'h00, 5);
        data = data_i;
        oe = data_oe_i;
        idle(4);
    endtask
endmodule

// >>> bench/nv_timekeeping_ram_core_tb.sv
// self-checking bench of the nonvolatile timekeeping memory core
`timescale 1ns/10ps
module nv_timekeeping_ram_core_tb;
    import nvtk_pkg::*;
    // shortened counts keep the run under a thousand cycles
    localparam int unsigned TICK  = 20;
    localparam int unsigned POR   = 10;
    localparam int unsigned WUNIT = 4;
    logic         clk      = 1'b0;
    logic         rst      = 1'b1;
    logic         power_ok = 1'b1;
    host_bus_type bus;
    logic [7:0]   data;
    logic         data_oe;
    logic         irq_n;
    logic         irq_n_oe;
    logic         rst_n;
    logic         rst_n_oe;
    logic         irq_pin;
    logic         rst_pin;
    int           errors     = 0;
    int           n_compared = 0;
    // 10 MHz clock
    always #50 clk = ~clk;
    nv_timekeeping_ram_core #(
        .TICK_CYCLES (TICK),
        .POR_CYCLES  (POR),
        .WDOG_UNIT   (WUNIT),
        .MEM_DEPTH   (32768)
    ) dut_u (
        .CLOCK_I    (clk),
        .RESET_I    (rst),
        .BUS_I      (bus),
        .DATA_O     (data),
        .DATA_OE_O  (data_oe),
        .POWER_OK_I (power_ok),
        .IRQ_N_I    (irq_pin),
        .IRQ_N_O    (irq_n),
        .IRQ_N_OE_O (irq_n_oe),
        .RST_N_I    (rst_pin),
        .RST_N_O    (rst_n),
        .RST_N_OE_O (rst_n_oe)
    );
    host_model host_u (
        .clk_i      (clk),
        .bus_o      (bus),
        .data_i     (data),
        .data_oe_i  (data_oe),
        .irq_n_i    (irq_n),
        .irq_n_oe_i (irq_n_oe),
        .rst_n_i    (rst_n),
        .rst_n_oe_i (rst_n_oe),
        .irq_pin_o  (irq_pin),
        .rst_pin_o  (rst_pin)
    );
    // verdict and end of run
    task automatic stop_test;
        if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // byte compare
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // single bit compare
    task automatic cmp1(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask
    // bounded wait on a pin enable, looked at mid-cycle: 0 interrupt, 1 reset
    task automatic wait_lvl(input int sel, input logic lvl, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            if ((sel == 0 ? irq_n_oe : rst_n_oe) === lvl) break;
        end
    endtask
    // plain storage at both ends, clock bytes on the same cycles
    task automatic s_ram;
        logic [7:0] d;
        logic       oe;
        host_u.wr(15'h0000, 8'h3C);
        host_u.wr(15'h0001, 8'h11);
        host_u.wr(15'h7FEF, 8'hC5);
        host_u.wr(15'h7FF3, 8'h5A);
        host_u.wr(15'h7FF0, 8'hFF);
        host_u.rd(15'h0000, d, oe);
        cmp8("ram_0000", 8'h3C, d);
        cmp1("read_drive", 1'b1, oe);
        host_u.rd(15'h7FEF, d, oe);
        cmp8("ram_7fef", 8'hC5, d);
        host_u.rd(15'h7FF3, d, oe);
        cmp8("clk_byte_7ff3", 8'h5A, d);
        host_u.rd(15'h7FF0, d, oe);
        cmp8("flags_not_ram", 8'h00, d);
    endtask
    // lines float when deselected or output enable is off
    task automatic s_float;
        logic [7:0] d;
        logic       oe;
        host_u.cyc(1'b1, 1'b0, 1'b0, 15'h0001, 8'h77, 5);
        cmp1("deselect_oe", 1'b0, data_oe);
        host_u.cyc(1'b0, 1'b1, 1'b1, 15'h0001, 8'h00, 5);
        cmp1("oe_off_float", 1'b0, data_oe);
        host_u.idle(4);
        host_u.rd(15'h0001, d, oe);
        cmp8("deselect_no_write", 8'h11, d);
    endtask
    // set 23:59:59 on 28 Feb 2024, day 7, and read across midnight
    task automatic s_calendar;
        logic [14:0] wa[9] = '{15'h7FF8, 15'h7FF9, 15'h7FFA, 15'h7FFB, 15'h7FFC,
                               15'h7FFD, 15'h7FFE, 15'h7FFF, 15'h7FF8};
        logic [7:0]  wd[9] = '{8'hA0, 8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h24, 8'h20};
        logic [14:0] ra[6] = '{15'h7FFD, 15'h7FFE, 15'h7FFF, 15'h7FFB, 15'h7FFA, 15'h7FFC};
        logic [7:0]  rv[6] = '{8'h29, 8'h02, 8'h24, 8'h00, 8'h00, 8'h01};
        logic [7:0]  s1;
        logic [7:0]  s2;
        logic        oe;
        for (int i = 0; i < 9; i++) host_u.wr(wa[i], wd[i]);
        repeat (3 * TICK) @(posedge clk);
        host_u.wr(15'h7FF8, 8'h60);
        for (int i = 0; i < 6; i++) begin
            host_u.rd(ra[i], s1, oe);
            cmp8("calendar", rv[i], s1);
        end
        // frozen copy must not move, the counting set must
        host_u.rd(15'h7FF9, s1, oe);
        repeat (3 * TICK) @(posedge clk);
        host_u.rd(15'h7FF9, s2, oe);
        cmp8("frozen_sec", s1, s2);
        host_u.wr(15'h7FF8, 8'h20);
        repeat (3 * TICK) @(posedge clk);
        host_u.wr(15'h7FF8, 8'h60);
        host_u.rd(15'h7FF9, s2, oe);
        cmp1("sec_advanced", 1'b1, s2 > s1);
        host_u.wr(15'h7FF8, 8'h20);
    endtask
    // every field masked, so the alarm matches each second
    task automatic s_alarm;
        logic [7:0] d;
        logic       oe;
        for (int i = 0; i < 4; i++) host_u.wr(15'(15'h7FF2 + i), 8'h80);
        host_u.wr(15'h7FF6, 8'h80);
        wait_lvl(0, 1'b1, 3 * TICK);
        cmp1("alarm_pin", 1'b1, irq_n_oe);
        cmp1("irq_pin_low", 1'b0, irq_pin);
        host_u.wr(15'h7FF6, 8'h00);
        host_u.rd(15'h7FF0, d, oe);
        cmp8("alarm_flag", 8'h40, d & 8'hC0);
        cmp1("alarm_off", 1'b0, irq_n_oe);
    endtask
    // watchdog steered to the interrupt, then to the reset pin
    task automatic s_wdog;
        logic [7:0] d;
        logic       oe;
        host_u.wr(15'h7FF7, 8'h02);
        wait_lvl(0, 1'b1, 4 * WUNIT + 10);
        cmp1("wdog_irq", 1'b1, irq_n_oe);
        host_u.wr(15'h7FF7, 8'h00);
        host_u.rd(15'h7FF0, d, oe);
        cmp8("wdog_flag", 8'h80, d & 8'h80);
        host_u.wr(15'h7FF7, 8'h81);
        wait_lvl(1, 1'b1, 4 * WUNIT + 10);
        cmp1("wdog_reset", 1'b1, rst_n_oe);
        host_u.wr(15'h7FF7, 8'h00);
        wait_lvl(1, 1'b0, POR + 10);
        cmp1("wdog_release", 1'b0, rst_n_oe);
        host_u.rd(15'h7FF0, d, oe);
        cmp8("wdog_rst_flag", 8'h80, d & 8'h80);
    endtask
    // supply loss: reset held, bus ignored, then timed release
    task automatic s_power;
        logic [7:0] d;
        logic       oe;
        int         n;
        host_u.wr(15'h7FF6, 8'hC0);
        power_ok <= 1'b0;
        wait_lvl(1, 1'b1, 6);
        cmp1("fail_reset", 1'b1, rst_n_oe);
        cmp1("rst_pin_low", 1'b0, rst_pin);
        host_u.wr(15'h0000, 8'hA5);
        host_u.rd(15'h0000, d, oe);
        cmp1("fail_float", 1'b0, oe);
        cmp1("battery_alarm", 1'b1, irq_n_oe);
        power_ok <= 1'b1;
        for (n = 0; n < POR + 20 && rst_n_oe === 1'b1; n++) @(negedge clk);
        cmp1("hold_min", 1'b1, n >= POR);
        cmp1("hold_max", 1'b1, n <= POR + 6);
        host_u.rd(15'h0000, d, oe);
        cmp8("kept_data", 8'h3C, d);
    endtask
    // main sequence after two cycles of reset
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        s_ram();
        s_float();
        s_calendar();
        s_alarm();
        s_wdog();
        s_power();
        stop_test();
    end
    // hang guard, well beyond the thousand or so cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test();
    end
endmodule
